// *** hdl/ocst_top.v ***
// Output clamp, coil check scheduling and logic self-test control.
// Assumes a register write port from the serial decoder and an encoder
// that frames the samples and acknowledge messages on the shared line.
`timescale 1ns/100ps
`include "ocst_defs.vh"

module ocst_top #(
    parameter COIL_ON_CYC = `OCST_COIL_ON_MS * `OCST_CYC_PER_MS,
    parameter COIL_OFF1_CYC = `OCST_COIL_OFF1_MS * `OCST_CYC_PER_MS,
    parameter COIL_OFF2_CYC = `OCST_COIL_OFF2_MS * `OCST_CYC_PER_MS,
    parameter TEST_CYC = `OCST_TEST_MS * `OCST_CYC_PER_MS,
    parameter TICK_CYC = 60
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Register port
    input wire [4:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [23:0] reg_wdata,
    output reg [23:0] reg_rdata,
    // Sample path
    input wire [11:0] lin_sample,
    input wire adc_over_range,
    output wire [11:0] out_sample,
    output reg out_sample_valid,
    // Coil front end
    input wire coil_dev_over,
    output reg coil_stim_sel,
    output wire coil_comp_on,
    // Logic test engine
    input wire logic_test_fail,
    output wire logic_test_run,
    // Shared line and encoder
    input wire [1:0] out_mode,
    input wire line_in,
    input wire msg_end,
    input wire data_window,
    input wire diag_fn_pulse,
    output reg out_hiz,
    output reg out_diag,
    output wire ack_valid,
    output wire ack_coil,
    output reg ack_pass,
    input wire ack_done
);

    localparam ST_IDLE = 5'b00001;
    localparam ST_TEST = 5'b00010;
    localparam ST_ACKL = 5'b00100;
    localparam ST_ACKA = 5'b01000;
    localparam ST_HOLD = 5'b10000;
    localparam [11:0] REQ_CYC = `OCST_REQ_TICKS * TICK_CYC;

    reg [23:0] limit_reg;
    reg [23:0] coil_reg;
    reg [23:0] trim_reg;
    reg [6:0] cfg_reg;
    reg [4:0] state_reg;
    reg [4:0] state_next;
    reg [10:0] smp_cnt_reg;
    reg [7:0] stim_cnt_reg;
    reg [11:0] chk_cnt_reg;
    reg [26:0] phase_cnt_reg;
    reg phase_on_reg;
    reg coil_err_reg;
    reg logic_fail_reg;
    reg abist_err_reg;
    reg oor_reg;
    reg [17:0] test_cnt_reg;
    reg [1:0] low_msgs_reg;
    reg msg_high_reg;
    reg [11:0] low_cnt_reg;
    reg trig_armed_reg;
    reg [26:0] off_cyc;
    wire [1:0] cadence;
    wire smp_tick;
    wire chk_tick;
    wire coil_active;
    wire sat_flag;
    wire line_req;
    wire reg_run;
    wire start;
    wire test_done;
    wire any_err;
    wire fault;

    // ==========================================================
    // Register writes
    assign reg_run = reg_wr && (reg_addr == `OCST_OFF_TEST) &&
        reg_wdata[`OCST_TEST_RUN];

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            limit_reg <= `OCST_LIMIT_RST;
            coil_reg <= `OCST_ZERO24;
            trim_reg <= `OCST_ZERO24;
            cfg_reg <= 7'h00;
        end else if (reg_wr) begin
            if (reg_addr == `OCST_OFF_LIMIT) begin
                limit_reg <= reg_wdata;
            end else if (reg_addr == `OCST_OFF_COIL) begin
                coil_reg <= reg_wdata;
            end else if (reg_addr == `OCST_OFF_TRIM) begin
                trim_reg <= reg_wdata;
            end else if (reg_addr == `OCST_OFF_CFG) begin
                cfg_reg <= reg_wdata[6:0];
            end
        end
    end

    // Reads are registered; unmapped offsets return zero.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `OCST_ZERO24;
        end else if (reg_rd) begin
            if (reg_addr == `OCST_OFF_LIMIT) begin
                reg_rdata <= limit_reg;
            end else if (reg_addr == `OCST_OFF_COIL) begin
                reg_rdata <= coil_reg;
            end else if (reg_addr == `OCST_OFF_TRIM) begin
                reg_rdata <= trim_reg;
            end else if (reg_addr == `OCST_OFF_CFG) begin
                reg_rdata <= {17'h00000, cfg_reg};
            end else if (reg_addr == `OCST_OFF_TEST) begin
                reg_rdata <= {19'h00000, state_reg == ST_HOLD, oor_reg,
                    coil_err_reg, logic_fail_reg, state_reg == ST_TEST};
            end else begin
                reg_rdata <= `OCST_ZERO24;
            end
        end
    end

    // ==========================================================
    // Rate dividers
    assign smp_tick = (smp_cnt_reg == `OCST_SMP_CYC - 1);
    assign chk_tick = (chk_cnt_reg == `OCST_CHK_CYC - 1);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            smp_cnt_reg <= 11'h000;
            chk_cnt_reg <= 12'h000;
            stim_cnt_reg <= 8'h00;
            coil_stim_sel <= 1'b0;
            out_sample_valid <= 1'b0;
        end else begin
            smp_cnt_reg <= smp_tick ? 11'h000 : smp_cnt_reg + 11'h001;
            chk_cnt_reg <= chk_tick ? 12'h000 : chk_cnt_reg + 12'h001;
            out_sample_valid <= smp_tick;
            if (!coil_active) begin
                stim_cnt_reg <= 8'h00;
                coil_stim_sel <= 1'b0;
            end else if (stim_cnt_reg == `OCST_STIM_CYC / 2 - 1) begin
                stim_cnt_reg <= 8'h00;
                coil_stim_sel <= ~coil_stim_sel;
            end else begin
                stim_cnt_reg <= stim_cnt_reg + 8'h01;
            end
        end
    end

    // ==========================================================
    // Sample path
    ocst_trim u_trim (
        .clk(clk),
        .rst_n(rst_n),
        .smp_tick(smp_tick),
        .lin_sample(lin_sample),
        .trim_cfg(trim_reg),
        .limit_cfg(limit_reg),
        .clamp_out(out_sample),
        .sat_flag(sat_flag)
    );

    // ==========================================================
    // Coil compensation cadence and coil check
    assign cadence = coil_reg[`OCST_CAD_MSB:`OCST_CAD_LSB];
    // Cadence 3 still drives the stimulus while a requested test runs.
    assign coil_active = (cadence != `OCST_CAD_OFF) ||
        (state_reg == ST_TEST);
    assign coil_comp_on = phase_on_reg && (cadence != `OCST_CAD_OFF) &&
        !cfg_reg[`OCST_CFG_COMP_DIS];

    always @* begin
        if (cadence == `OCST_CAD_0) begin
            off_cyc = 27'd0;
        end else if (cadence == `OCST_CAD_1) begin
            off_cyc = COIL_OFF1_CYC[26:0];
        end else begin
            off_cyc = COIL_OFF2_CYC[26:0];
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_cnt_reg <= 27'd0;
            phase_on_reg <= 1'b1;
        end else if (cadence == `OCST_CAD_OFF) begin
            phase_cnt_reg <= 27'd0;
            phase_on_reg <= 1'b1;
        end else if (phase_on_reg &&
                phase_cnt_reg >= COIL_ON_CYC[26:0] - 27'd1) begin
            phase_cnt_reg <= 27'd0;
            phase_on_reg <= (off_cyc == 27'd0);
        end else if (!phase_on_reg && phase_cnt_reg >= off_cyc - 27'd1) begin
            phase_cnt_reg <= 27'd0;
            phase_on_reg <= 1'b1;
        end else begin
            phase_cnt_reg <= phase_cnt_reg + 27'd1;
        end
    end

    // The verdict only moves in the on phase while cadence is not 3.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            coil_err_reg <= 1'b0;
        end else if (chk_tick && phase_on_reg &&
                cadence != `OCST_CAD_OFF) begin
            coil_err_reg <= coil_dev_over;
        end
    end

    // ==========================================================
    // Fault reporting
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oor_reg <= 1'b0;
        end else if (smp_tick) begin
            oor_reg <= sat_flag || adc_over_range;
        end
    end

    assign fault = (oor_reg && !cfg_reg[`OCST_CFG_OOR_DIS]) ||
        (coil_err_reg && cadence != `OCST_CAD_OFF &&
        !cfg_reg[`OCST_CFG_COIL_REP_DIS]);

    // ==========================================================
    // Self-test requests from the line
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_msgs_reg <= 2'h0;
            msg_high_reg <= 1'b0;
            low_cnt_reg <= 12'h000;
            trig_armed_reg <= 1'b0;
        end else begin
            if (out_mode != `OCST_MODE_CONT || state_reg != ST_IDLE) begin
                low_msgs_reg <= 2'h0;
                msg_high_reg <= 1'b0;
            end else if (msg_end) begin
                // A message counts only if the line never went high in it.
                low_msgs_reg <= (msg_high_reg || line_in) ? 2'h0 :
                    low_msgs_reg + 2'h1;
                msg_high_reg <= 1'b0;
            end else if (line_in) begin
                msg_high_reg <= 1'b1;
            end
            if (out_mode != `OCST_MODE_TRIG || state_reg != ST_IDLE) begin
                low_cnt_reg <= 12'h000;
                trig_armed_reg <= 1'b0;
            end else if (line_in) begin
                low_cnt_reg <= 12'h000;
                trig_armed_reg <= 1'b0;
            end else if (data_window && !trig_armed_reg) begin
                if (low_cnt_reg == REQ_CYC - 12'h001) begin
                    trig_armed_reg <= 1'b1;
                end
                low_cnt_reg <= low_cnt_reg + 12'h001;
            end
        end
    end

    // The triggered request fires when the controller releases the line.
    assign line_req =
        (out_mode == `OCST_MODE_CONT && low_msgs_reg == 2'h2) ||
        (out_mode == `OCST_MODE_TRIG && trig_armed_reg && line_in) ||
        (out_mode[1] && diag_fn_pulse);

    // ==========================================================
    // Self-test sequence
    assign start = (state_reg == ST_IDLE) &&
        cfg_reg[`OCST_CFG_TEST_EN] && (line_req || reg_run);
    assign test_done = (test_cnt_reg == TEST_CYC[17:0] - 18'd1);
    assign logic_test_run = (state_reg == ST_TEST);
    assign ack_valid = (state_reg == ST_ACKL) || (state_reg == ST_ACKA);
    assign ack_coil = (state_reg == ST_ACKA);
    assign any_err = logic_fail_reg || abist_err_reg;

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    state_next = ST_TEST;
                end
            end
            ST_TEST: begin
                if (test_done) begin
                    if (cfg_reg[`OCST_CFG_ACK_LOGIC]) begin
                        state_next = ST_ACKL;
                    end else if (cfg_reg[`OCST_CFG_ACK_COIL]) begin
                        state_next = ST_ACKA;
                    end else if (logic_test_fail || (cadence ==
                            `OCST_CAD_OFF && coil_dev_over)) begin
                        state_next = ST_HOLD;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_ACKL: begin
                if (ack_done) begin
                    if (cfg_reg[`OCST_CFG_ACK_COIL]) begin
                        state_next = ST_ACKA;
                    end else begin
                        state_next = any_err ? ST_HOLD : ST_IDLE;
                    end
                end
            end
            ST_ACKA: begin
                if (ack_done) begin
                    state_next = any_err ? ST_HOLD : ST_IDLE;
                end
            end
            ST_HOLD: begin
                state_next = ST_HOLD;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            test_cnt_reg <= 18'd0;
            logic_fail_reg <= 1'b0;
            abist_err_reg <= 1'b0;
            ack_pass <= 1'b1;
        end else begin
            state_reg <= state_next;
            test_cnt_reg <= (state_reg == ST_TEST) ?
                test_cnt_reg + 18'd1 : 18'd0;
            if (start) begin
                logic_fail_reg <= 1'b0;
                abist_err_reg <= 1'b0;
            end else if (state_reg == ST_TEST && test_done) begin
                logic_fail_reg <= logic_test_fail;
                // The coil verdict is only trusted with cadence 3.
                abist_err_reg <= (cadence == `OCST_CAD_OFF) &&
                    coil_dev_over;
            end
            if (state_next == ST_ACKL) begin
                // The verdict register is only loaded at this same edge.
                ack_pass <= (state_reg == ST_TEST) ? !logic_test_fail :
                    !logic_fail_reg;
            end else if (state_next == ST_ACKA) begin
                ack_pass <= (state_reg == ST_TEST) ?
                    !(cadence == `OCST_CAD_OFF && coil_dev_over) :
                    !abist_err_reg;
            end
        end
    end

    // ==========================================================
    // Output line state
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_hiz <= 1'b1;
            out_diag <= 1'b0;
        end else begin
            out_hiz <= (state_next == ST_TEST) || (state_next == ST_HOLD) ||
                (fault && cfg_reg[`OCST_CFG_FAULT_HIZ]);
            out_diag <= fault && !cfg_reg[`OCST_CFG_FAULT_HIZ];
        end
    end

endmodule // ocst_top

// *** hdl/ocst_trim.v ***
// Post-linearization gain and offset trim followed by the output clamp.
// Assumes smp_tick is a one-cycle strobe at the output sample rate.
`timescale 1ns/100ps
`include "ocst_defs.vh"

module ocst_trim (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Sample strobe and linearized input
    input wire smp_tick,
    input wire [11:0] lin_sample,
    // Settings
    input wire [23:0] trim_cfg,
    input wire [23:0] limit_cfg,
    // Result
    output reg [11:0] clamp_out,
    output reg sat_flag
);

    wire signed [11:0] s_in;
    wire signed [11:0] gain;
    wire signed [11:0] ofs;
    wire signed [23:0] prod;
    wire signed [13:0] sum;
    reg signed [11:0] sat;
    reg [11:0] uns;
    reg [11:0] lim;
    wire [11:0] lim_hi;
    wire [11:0] lim_lo;

    // ==========================================================
    // Gain and offset trim
    assign s_in = lin_sample;
    assign gain = trim_cfg[`OCST_GAIN_MSB:`OCST_GAIN_LSB];
    assign ofs = trim_cfg[`OCST_OFS_MSB:`OCST_OFS_LSB];
    assign prod = s_in * gain;
    // Sample plus sample times gain at 2^-11, then the offset.
    assign sum = {{2{s_in[11]}}, s_in} + {prod[23], prod[23:11]} +
        {{2{ofs[11]}}, ofs};
    assign lim_hi = limit_cfg[`OCST_LIM_HI_MSB:`OCST_LIM_HI_LSB];
    assign lim_lo = limit_cfg[`OCST_LIM_LO_MSB:`OCST_LIM_LO_LSB];

    // ==========================================================
    // Saturation, offset binary and clamp
    always @* begin
        if (sum > `OCST_SMAX) begin
            sat = `OCST_SMAX12;
        end else if (sum < $signed(`OCST_SMIN)) begin
            sat = `OCST_SMIN12;
        end else begin
            sat = sum[11:0];
        end
        // Adding 2048 to a 12-bit signed value only flips its top bit.
        uns = {~sat[11], sat[10:0]};
        // Limits crossed over give lim_hi above it, else lim_lo; software keeps order.
        if (uns > lim_hi) begin
            lim = lim_hi;
        end else if (uns < lim_lo) begin
            lim = lim_lo;
        end else begin
            lim = uns;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clamp_out <= 12'h000;
            sat_flag <= 1'b0;
        end else if (smp_tick) begin
            clamp_out <= lim;
            sat_flag <= (sum > `OCST_SMAX) || (sum < $signed(`OCST_SMIN));
        end
    end

endmodule // ocst_trim

// *** shared/ocst_defs.vh ***
// Constants for the output clamp and self-test control block.
// Assumes a 20 MHz core clock and the register write port of ocst_top.
`ifndef OCST_DEFS_VH
`define OCST_DEFS_VH

// ==========================================================
// Register offsets
`define OCST_ADDR_W 5
`define OCST_OFF_LIMIT 5'h08
`define OCST_OFF_COIL 5'h09
`define OCST_OFF_CFG 5'h0B
`define OCST_OFF_TEST 5'h0C
`define OCST_OFF_TRIM 5'h13

// ==========================================================
// Field positions
`define OCST_LIM_HI_MSB 11
`define OCST_LIM_HI_LSB 0
`define OCST_LIM_LO_MSB 23
`define OCST_LIM_LO_LSB 12
`define OCST_GAIN_MSB 11
`define OCST_GAIN_LSB 0
`define OCST_OFS_MSB 23
`define OCST_OFS_LSB 12
`define OCST_CAD_MSB 14
`define OCST_CAD_LSB 13
`define OCST_CFG_TEST_EN 0
`define OCST_CFG_ACK_LOGIC 1
`define OCST_CFG_ACK_COIL 2
`define OCST_CFG_FAULT_HIZ 3
`define OCST_CFG_COIL_REP_DIS 4
`define OCST_CFG_COMP_DIS 5
`define OCST_CFG_OOR_DIS 6
`define OCST_TEST_RUN 0
`define OCST_TEST_FAIL 1
`define OCST_TEST_COIL_ERR 2
`define OCST_TEST_OOR 3
`define OCST_TEST_HOLD 4

// ==========================================================
// Reset values and codes
`define OCST_LIMIT_RST 24'h000FFF
`define OCST_ZERO24 24'h000000
`define OCST_CAD_OFF 2'h3
`define OCST_CAD_0 2'h0
`define OCST_CAD_1 2'h1
`define OCST_SMAX 14'sh07FF
`define OCST_SMIN 14'sh3800
`define OCST_SMAX12 12'h7FF
`define OCST_SMIN12 12'h800
`define OCST_MODE_CONT 2'h0
`define OCST_MODE_TRIG 2'h1

// ==========================================================
// Timing
`define OCST_CLK_HZ 20000000
`define OCST_SMP_HZ 16000
`define OCST_STIM_HZ 128000
`define OCST_CHK_HZ 8000
`define OCST_SMP_CYC (`OCST_CLK_HZ / `OCST_SMP_HZ)
`define OCST_STIM_CYC (`OCST_CLK_HZ / `OCST_STIM_HZ)
`define OCST_CHK_CYC (`OCST_CLK_HZ / `OCST_CHK_HZ)
`define OCST_CYC_PER_MS (`OCST_CLK_HZ / 1000)
`define OCST_COIL_ON_MS 16
`define OCST_COIL_OFF1_MS 16
`define OCST_COIL_OFF2_MS 4080
`define OCST_TEST_MS 10
`define OCST_REQ_TICKS 15

`endif

// *** tb/ocst_asserts.sv ***
// Checker for sample timing and self-test sequencing of ocst_top.
// Sees only the top ports; attached by the bind at the foot.
`timescale 1ns/100ps
module ocst_asserts #(parameter TEST_CYC = 50) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Watched outputs
    input wire [11:0] out_sample,
    input wire out_sample_valid,
    input wire coil_stim_sel,
    input wire logic_test_run,
    input wire out_hiz,
    input wire ack_valid,
    input wire ack_pass
);
// ==========================================================
// Helper counters
reg [10:0] smp_cnt;
reg [6:0] stim_cnt;
reg [15:0] run_cnt;
reg smp_seen;
reg stim_seen;
reg stim_last;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        smp_cnt <= 11'h000;
        stim_cnt <= 7'h00;
        run_cnt <= 16'h0000;
        smp_seen <= 1'b0;
        stim_seen <= 1'b0;
        stim_last <= 1'b0;
    end else begin
        smp_cnt <= out_sample_valid ? 11'h000 : smp_cnt + 11'h001;
        smp_seen <= smp_seen | out_sample_valid;
        stim_last <= coil_stim_sel;
        stim_seen <= stim_seen | (coil_stim_sel != stim_last);
        stim_cnt <= (coil_stim_sel != stim_last) ? 7'h00 : stim_cnt + 7'h01;
        run_cnt <= logic_test_run ? run_cnt + 16'h0001 : 16'h0000;
    end
end
// ==========================================================
// Properties
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
valid_pulse_a: assert property (out_sample_valid |=> !out_sample_valid)
    else $error("sample strobe longer than one cycle");
sample_rate_a: assert property (out_sample_valid && smp_seen |->
    smp_cnt == 11'h4E1) else $error("sample spacing is not 1250 cycles");
sample_hold_a: assert property (!out_sample_valid |-> $stable(out_sample))
    else $error("sample changed without strobe");
stim_rate_a: assert property ($rose(coil_stim_sel) && stim_seen |->
    stim_cnt == 7'h4D) else $error("stimulus phase is not 78 cycles");
test_hiz_a: assert property (logic_test_run |-> out_hiz)
    else $error("output driven during self-test");
test_len_a: assert property ($fell(logic_test_run) |->
    run_cnt == TEST_CYC) else $error("self-test length wrong");
ack_quiet_a: assert property (ack_valid |-> !logic_test_run)
    else $error("acknowledge while test runs");
fail_hold_a: assert property ($fell(ack_valid) && !ack_pass |->
    ##[1:2] out_hiz [*8]) else $error("output resumed after failure");
cover property (out_sample_valid && smp_seen);
cover property ($fell(logic_test_run));
cover property ($fell(ack_valid) && !ack_pass);
endmodule // ocst_asserts

bind ocst_top ocst_asserts #(.TEST_CYC(TEST_CYC)) chk (.clk, .rst_n,
    .out_sample, .out_sample_valid, .coil_stim_sel, .logic_test_run,
    .out_hiz, .ack_valid, .ack_pass);

// *** tb/ocst_ctl.sv ***
// Model of the engine controller on the shared open-drain line.
// Assumes a pull-up on the line; the bench calls request and sets ack_dly.
`timescale 1ns/100ps
module ocst_ctl #(parameter MSG_CYC = 100, parameter REQ_CYC = 30) (
    input wire clk,
    input wire ack_valid,
    output reg line_in,
    output reg msg_end,
    output reg data_window,
    output reg diag_fn_pulse,
    output reg ack_done
);
// ==========================================================
// Message timing and acknowledge answers
reg [7:0] pos = 8'h00;
integer ack_dly = 1;
initial begin
    line_in = 1'b1;
    msg_end = 1'b0;
    data_window = 1'b0;
    diag_fn_pulse = 1'b0;
    ack_done = 1'b0;
end
always @(negedge clk) begin
    pos <= (pos == MSG_CYC - 1) ? 8'h00 : pos + 8'h01;
    msg_end <= (pos == MSG_CYC - 1);
    data_window <= (pos >= 8'h14) && (pos < 8'h50);
end
always @(negedge clk) begin
    if (ack_valid === 1'b1) begin
        repeat (ack_dly) @(negedge clk);
        ack_done <= 1'b1;
        @(negedge clk);
        ack_done <= 1'b0;
        repeat (2) @(negedge clk);
    end
end
task request(input [1:0] mode);
    begin
        if (mode == 2'h0) begin
            @(posedge msg_end);
            line_in = 1'b0;
            repeat (2) @(posedge msg_end);
            @(negedge clk);
            line_in = 1'b1;
        end else if (mode == 2'h1) begin
            @(posedge data_window);
            @(negedge clk);
            line_in = 1'b0;
            repeat (REQ_CYC) @(negedge clk);
            line_in = 1'b1;
        end else begin
            @(negedge clk);
            diag_fn_pulse = 1'b1;
            @(negedge clk);
            diag_fn_pulse = 1'b0;
        end
    end
endtask
endmodule // ocst_ctl

// *** tb/tb_top.sv ***
// Self-checking bench for ocst_top with the controller model.
// Inputs change at the falling edge; short test and tick lengths are used.
`timescale 1ns/100ps
module tb_top;
reg clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tst_fail = 1'b0;
reg [4:0] reg_addr = 5'h00;
reg [23:0] reg_wdata = 24'h000000, trim, lim;
reg [11:0] lin = 12'h000;
reg [1:0] out_mode = 2'h0;
reg adc_ovr = 1'b0, coil_dev = 1'b0;
reg [31:0] seed = 32'h2C6434C1;
wire [23:0] reg_rdata;
wire [11:0] out_sample;
wire out_sample_valid, ln, me, dw, dp, out_hiz, ack_valid, ack_coil, ack_pass;
wire ack_done, logic_test_run, out_diag, coil_comp_on;
integer bad_count = 0, cmp_count = 0, i, n;
ocst_top #(.COIL_ON_CYC(40), .COIL_OFF1_CYC(40), .COIL_OFF2_CYC(200),
    .TEST_CYC(50), .TICK_CYC(2)) uut (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .lin_sample(lin),
    .adc_over_range(adc_ovr), .out_sample(out_sample),
    .out_sample_valid(out_sample_valid), .coil_dev_over(coil_dev),
    .coil_stim_sel(), .coil_comp_on(coil_comp_on), .logic_test_fail(tst_fail),
    .logic_test_run(logic_test_run), .out_mode(out_mode), .line_in(ln),
    .msg_end(me), .data_window(dw), .diag_fn_pulse(dp), .out_hiz(out_hiz),
    .out_diag(out_diag), .ack_valid(ack_valid), .ack_coil(ack_coil),
    .ack_pass(ack_pass), .ack_done(ack_done));
ocst_ctl ctl (.clk(clk), .ack_valid(ack_valid), .line_in(ln), .msg_end(me),
    .data_window(dw), .diag_fn_pulse(dp), .ack_done(ack_done));
always #25 clk = ~clk;
// ==========================================================
// Helpers
function [31:0] xs(input [31:0] s);
    begin
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        xs = s ^ (s << 5);
    end
endfunction
function [11:0] exp_out(input [11:0] x, input [23:0] t, input [23:0] l);
    integer s;
    begin
        s = $signed(x);
        s = s + ((s * $signed(t[11:0])) >>> 11) + $signed(t[23:12]);
        if (s > 2047) s = 2047;
        if (s < -2048) s = -2048;
        s = s + 2048;
        if (s > l[11:0]) s = l[11:0];
        else if (s < l[23:12]) s = l[23:12];
        exp_out = s[11:0];
    end
endfunction
function ok(input [2:0] k);
    case (k)
        3'h0: ok = out_sample_valid;
        3'h1: ok = logic_test_run;
        3'h2: ok = ack_valid;
        3'h3: ok = ack_valid & ack_coil;
        default: ok = ~ack_valid;
    endcase
endfunction
task give_verdict;
    begin
        if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    end
endtask
task cmp(input [23:0] got, input [23:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    end
endtask
task wait_for(input [2:0] k, input integer lim_c);
    begin
        n = 0;
        while (ok(k) !== 1'b1 && n < lim_c) begin
            @(negedge clk);
            n = n + 1;
        end
        if (n >= lim_c) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: wait %0d timed out", $time, k);
            give_verdict;
        end
    end
endtask
task wr(input [4:0] a, input [23:0] d);
    begin
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    end
endtask
task rd_cmp(input [4:0] a, input [23:0] m, input [23:0] e);
    begin
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        cmp(reg_rdata & m, e);
    end
endtask
// ==========================================================
// Main sequence
initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    rd_cmp(5'h08, 24'hFFFFFF, 24'h000FFF);
    rd_cmp(5'h13, 24'hFFFFFF, 24'h000000);
    rd_cmp(5'h1F, 24'hFFFFFF, 24'h000000);
    for (i = 0; i < 8; i = i + 1) begin
        seed = xs(seed);
        trim = {seed[23:12], seed[0] ? 12'h800 : 12'h000};
        lim = {1'b0, seed[30:20], 1'b1, seed[10:0]};
        lin = seed[31:20];
        if (i == 0) trim = 24'h7FF000;
        if (i < 2) lin = i ? 12'h800 : 12'h7FF;
        if (i == 1) trim = 24'h800000;
        wait_for(3'h0, 1300);
        wr(5'h13, trim);
        wr(5'h08, lim);
        wait_for(3'h0, 1300);
        cmp(out_sample, exp_out(lin, trim, lim));
        if (i == 2) cmp(out_diag, 1);
    end
    wr(5'h0B, 24'h000007);
    for (i = 0; i < 5; i = i + 1) begin
        ctl.ack_dly = (i % 2) ? 20 : 1;
        out_mode = i;
        if (i == 4) wr(5'h0C, 24'h000001);
        else ctl.request(out_mode);
        wait_for(3'h1, 600);
        cmp(out_hiz, 1);
        wait_for(3'h2, 200);
        cmp({ack_coil, ack_pass}, 1);
        wait_for(3'h3, 200);
        wait_for(3'h4, 200);
        repeat (3) @(negedge clk);
        cmp(out_hiz, 0);
    end
    wr(5'h0B, 24'h000008);
    adc_ovr = 1'b1;
    @(negedge clk);
    wait_for(3'h0, 1300);
    @(negedge clk);
    cmp({out_hiz, out_diag, coil_comp_on}, 24'h000005);
    adc_ovr = 1'b0;
    coil_dev = 1'b1;
    wr(5'h0B, 24'h000060);
    repeat (2600) @(negedge clk);
    cmp({coil_comp_on, out_diag}, 24'h000001);
    wr(5'h0B, 24'h000070);
    @(negedge clk);
    cmp(out_diag, 0);
    coil_dev = 1'b0;
    wr(5'h0B, 24'h000006);
    wr(5'h0C, 24'h000001);
    repeat (5) @(negedge clk);
    cmp(logic_test_run, 0);
    wr(5'h0B, 24'h000003);
    tst_fail = 1'b1;
    wr(5'h0C, 24'h000001);
    wait_for(3'h2, 200);
    cmp(ack_pass, 0);
    wait_for(3'h4, 200);
    repeat (20) @(negedge clk);
    cmp(out_hiz, 1);
    rd_cmp(5'h0C, 24'h000012, 24'h000012);
    give_verdict;
end
endmodule // tb_top
